// ---- rtl/dsh_map.svh ----
/*
  Offsets, frame bytes, reset values and exception codes of the destination
  serial, exception filter and traffic hold register group.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef DSH_MAP_SVH
`define DSH_MAP_SVH

// ****************************************
// Volatile locations
// ****************************************
`define DSH_OFF_DSN3        8'h68
`define DSH_OFF_DSN2        8'h69
`define DSH_OFF_DSN1        8'h6a
`define DSH_OFF_DSN0        8'h6b
`define DSH_OFF_EXF         8'h6c
`define DSH_OFF_HOLD        8'h6e
`define DSH_OFF_EXC         8'h6d

// ****************************************
// Non-volatile locations
// ****************************************
`define DSH_OFF_DSN3_NV     8'h1d
`define DSH_OFF_DSN2_NV     8'h1e
`define DSH_OFF_DSN1_NV     8'h1f
`define DSH_OFF_DSN0_NV     8'h20
`define DSH_OFF_EXF_NV      8'h21
`define DSH_OFF_HOLD_NV     8'h23

// ****************************************
// Command frame bytes
// ****************************************
`define DSH_HDR             8'hff
`define DSH_SIZE            8'h02
`define DSH_ESC             8'hfe
`define DSH_ACK             8'h06

// ****************************************
// Reset values and settings
// ****************************************
`define DSH_RST_DSN         8'h00
`define DSH_RST_EXF         8'hff
`define DSH_RST_HOLD        8'h00
`define DSH_HOLD_ON         8'h01

// ****************************************
// Exception codes, one bit group per class
// ****************************************
`define DSH_EXC_HOST_OVF    8'h08
`define DSH_EXC_RADIO_OVF   8'h09
`define DSH_EXC_WR_FAIL     8'h10
`define DSH_EXC_NO_ACK      8'h20
`define DSH_EXC_BAD_CSUM    8'h40
`define DSH_EXC_BAD_HDR     8'h41
`define DSH_EXC_BAD_SEQ     8'h42
`define DSH_EXC_BAD_FTYPE   8'h43

// ****************************************
// Buffer sizes
// ****************************************
`define DSH_RF_DEPTH        64
`define DSH_RF_AW           6

`endif

// ---- rtl/dsh_pkg.sv ----
/*
  Types shared by the register group and its output buffer.
  Assumes the map header sits beside it.
*/
`default_nettype none
package dsh_pkg;
  `include "dsh_map.svh"

  // One byte plus its command-response marker
  typedef struct packed {
    logic       is_data;   // High marks received radio data
    logic [7:0] data;      // Byte to send
  } dsh_byte_t;

  // Command parser states
  typedef enum logic [2:0] {
    DSH_IDLE = 3'b000,
    DSH_SIZE_ST = 3'b001,
    DSH_ADDR = 3'b010,
    DSH_RADDR = 3'b011,
    DSH_VAL = 3'b100
  } dsh_cmd_t;

  // Read answer states
  typedef enum logic [1:0] {
    DSH_ANS_IDLE = 2'b00,
    DSH_ANS_ACK = 2'b01,
    DSH_ANS_ADR = 2'b10,
    DSH_ANS_VAL = 2'b11
  } dsh_ans_t;
endpackage : dsh_pkg
`default_nettype wire

// ---- rtl/dsh_skid.sv ----
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dsh_skid
  import dsh_pkg::*;
(
  input  wire logic      clock,
  input  wire logic      rst,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire dsh_byte_t in_data,
  output logic           out_valid,
  input  wire logic      out_ready,
  output dsh_byte_t      out_data
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    dsh_byte_t  e0;    // Head entry
    dsh_byte_t  e1;    // Second entry
    logic [1:0] cnt;   // Entries held
    logic       vld;   // Output valid, kept in a flop for the top's ports
  } dsh_skid_st_t;

  dsh_skid_st_t st_reg;    // Registered state
  dsh_skid_st_t st_next;   // Next state

  assign in_ready  = (st_reg.cnt != 2'h2);
  assign out_valid = st_reg.vld;
  assign out_data  = st_reg.e0;

  // Push and pop in one pass; both may happen together
  always_comb
  begin
    logic push;
    logic pop;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    st_next = st_reg;
    if (pop)
    begin
      st_next.e0 = st_reg.e1;
    end
    if (push)
    begin
      // Landing slot depends on what remains after the pop
      if ((st_reg.cnt == 2'd0) || (st_reg.cnt == 2'd1 && pop))
        st_next.e0 = in_data;
      else
        st_next.e1 = in_data;
    end
    st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
    st_next.vld = (st_next.cnt != 2'h0);
  end

  // Register the state
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule : dsh_skid
`default_nettype wire

// ---- rtl/dsh_regs.sv ----
/*
  Destination serial number, exception filter and traffic hold registers with
  their command parser, exception line, held radio buffer and serial output.
  Assumes bytes arrive already deserialised on a one-cycle strobe from the
  command port, and that radio bytes and exception events are strobes on the
  same clock. Command line and receive-packet option come from pins.
*/
// Operation
// - Four destination serial bytes, volatile and stored.
// - One command per serial byte location.
// - Masked exception code nonzero raises line.
// - Reading exception code clears line.
// - Masked zero still records the code.
// - Filter 0x08 passes overflow exceptions only.
// - Filter 0x10 passes write failure only.
// - Filter 0x20 passes missing acknowledgement only.
// - Filter 0x40 passes reception errors only.
// - Filter 0xff passes every exception.
// - Hold on buffers radio data while low.
// - Command line high releases held data.
// - Hold off sends bytes marked as data.
// - Receive-packet option overrides traffic hold.
// - Filter at 0x6c, stored copy 0x21.
// - Traffic hold at 0x6e, stored copy 0x23.
`timescale 1ns/1ps
`default_nettype none
`include "dsh_map.svh"
module dsh_regs
  import dsh_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       rf_valid,
  input  wire logic [7:0] rf_byte,
  input  wire logic       exc_valid,
  input  wire logic [7:0] exc_code,
  input  wire logic       cmd_line_n,
  input  wire logic       receive_packet_option,
  output logic            tx_valid,
  output logic [7:0]      tx_byte,
  output logic            command_response_line,
  input  wire logic       tx_ready,
  output logic            exception_output_line,
  output logic            rf_overflow,
  output logic [31:0]     destination_serial_number
);

  // ****************************************
  // State of the block
  // ****************************************
  typedef struct packed {
    logic [3:0][7:0] device_serial_number;          // Volatile serial, index 3 is MSB
    logic [3:0][7:0] dsn_nv;       // Stored serial copy
    logic [7:0]      exf;          // Volatile exception filter
    logic [7:0]      exf_nv;       // Stored filter copy
    logic [7:0]      hold;         // Volatile traffic hold
    logic [7:0]      hold_nv;      // Stored hold copy
    logic [7:0]      exc_code_reg; // Last exception code
    logic            ex_line;      // Exception output line
    dsh_cmd_t        cmd;          // Parser state
    logic [7:0]      addr;         // Addressed location
    dsh_ans_t        ans;          // Answer state
    logic [7:0]      ans_addr;     // Address echoed in the answer
    logic [7:0]      ans_val;      // Value returned
    logic [`DSH_RF_AW:0] wp;       // Radio buffer write pointer
    logic [`DSH_RF_AW:0] rp;       // Radio buffer read pointer
    logic            ovf;          // Radio buffer dropped a byte
    logic [1:0]      cmd_sync;     // Command line synchroniser
    logic [1:0]      rxp_sync;     // Receive-packet synchroniser
  } dsh_st_t;

  localparam logic [7:0] EXC_READ_OFF = `DSH_OFF_EXC;   // Exception code location

  dsh_st_t st_reg;    // Registered state
  dsh_st_t st_next;   // Next state

  // Radio buffer memory, outside the struct so it needs no reset
  logic [7:0] rf_mem [`DSH_RF_DEPTH];

  // Buffer handshake wires
  logic      buf_in_valid;   // Byte offered to the output buffer
  logic      buf_in_ready;   // Output buffer can take it
  dsh_byte_t buf_in;         // Offered byte
  logic      buf_out_valid;  // Output buffer holds a byte
  dsh_byte_t buf_out;        // Head of the output buffer

  // ****************************************
  // Derived conditions
  // ****************************************
  logic cmd_high;     // Synchronised command line
  logic rxp;          // Synchronised receive-packet option
  logic holding;      // Radio data must wait
  logic rf_empty;     // Radio buffer empty
  logic rf_full;      // Radio buffer full
  logic ans_push;     // Answer byte goes out this cycle
  logic rf_push;      // Radio byte goes out this cycle

  assign cmd_high = st_reg.cmd_sync[1];
  assign rxp      = st_reg.rxp_sync[1];
  // Packet mode ignores the hold setting entirely
  assign holding  = (st_reg.hold == `DSH_HOLD_ON) && !rxp && !cmd_high;
  assign rf_empty = (st_reg.wp == st_reg.rp);
  assign rf_full  = (st_reg.wp[`DSH_RF_AW] != st_reg.rp[`DSH_RF_AW]) &&
                    (st_reg.wp[`DSH_RF_AW-1:0] == st_reg.rp[`DSH_RF_AW-1:0]);
  // Answers win the output over radio data so a read never stalls long
  assign ans_push = (st_reg.ans != DSH_ANS_IDLE) && buf_in_ready;
  assign rf_push  = !ans_push && !rf_empty && !holding && buf_in_ready;

  // ****************************************
  // Output buffer feed
  // ****************************************
  always_comb
  begin
    buf_in_valid = ans_push || rf_push;
    buf_in       = '0;
    unique case (st_reg.ans)
      DSH_ANS_ACK: buf_in.data = `DSH_ACK;
      DSH_ANS_ADR: buf_in.data = st_reg.ans_addr;
      DSH_ANS_VAL: buf_in.data = st_reg.ans_val;
      DSH_ANS_IDLE:
      begin
        // Radio bytes carry the data marker
        buf_in.data    = rf_mem[st_reg.rp[`DSH_RF_AW-1:0]];
        buf_in.is_data = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Register read decode
  // ****************************************
  function automatic logic [7:0] dsh_read(input dsh_st_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    // Each serial byte has its own location
    unique case (a)
      `DSH_OFF_DSN3:    v = s.device_serial_number[3];
      `DSH_OFF_DSN2:    v = s.device_serial_number[2];
      `DSH_OFF_DSN1:    v = s.device_serial_number[1];
      `DSH_OFF_DSN0:    v = s.device_serial_number[0];
      `DSH_OFF_DSN3_NV: v = s.dsn_nv[3];
      `DSH_OFF_DSN2_NV: v = s.dsn_nv[2];
      `DSH_OFF_DSN1_NV: v = s.dsn_nv[1];
      `DSH_OFF_DSN0_NV: v = s.dsn_nv[0];
      `DSH_OFF_EXF:     v = s.exf;
      `DSH_OFF_EXF_NV:  v = s.exf_nv;
      `DSH_OFF_HOLD:    v = s.hold;
      `DSH_OFF_HOLD_NV: v = s.hold_nv;
      EXC_READ_OFF:     v = s.exc_code_reg;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction : dsh_read

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic exc_clear;
    exc_clear = 1'b0;
    st_next = st_reg;

    // Pin synchronisers
    st_next.cmd_sync = {st_reg.cmd_sync[0], cmd_line_n};
    st_next.rxp_sync = {st_reg.rxp_sync[0], receive_packet_option};

    // Command parser
    if (cmd_valid)
    begin
      unique case (st_reg.cmd)
        DSH_IDLE:
          if (cmd_byte == `DSH_HDR)
            st_next.cmd = DSH_SIZE_ST;
        DSH_SIZE_ST:
          st_next.cmd = (cmd_byte == `DSH_SIZE) ? DSH_ADDR : DSH_IDLE;
        DSH_ADDR:
        begin
          // Escape marks a read, anything else is a write address
          if (cmd_byte == `DSH_ESC)
            st_next.cmd = DSH_RADDR;
          else
          begin
            st_next.addr = cmd_byte;
            st_next.cmd  = DSH_VAL;
          end
        end
        DSH_RADDR:
        begin
          // A new read takes over address and value; the answer restarts at the ack only if no answer byte goes out this cycle
          st_next.ans      = DSH_ANS_ACK;
          st_next.ans_addr = cmd_byte;
          st_next.ans_val  = dsh_read(st_reg, cmd_byte);
          exc_clear        = (cmd_byte == EXC_READ_OFF);
          st_next.cmd      = DSH_IDLE;
        end
        DSH_VAL:
        begin
          unique case (st_reg.addr)
            `DSH_OFF_DSN3:    st_next.device_serial_number[3]    = cmd_byte;
            `DSH_OFF_DSN2:    st_next.device_serial_number[2]    = cmd_byte;
            `DSH_OFF_DSN1:    st_next.device_serial_number[1]    = cmd_byte;
            `DSH_OFF_DSN0:    st_next.device_serial_number[0]    = cmd_byte;
            `DSH_OFF_DSN3_NV: st_next.dsn_nv[3] = cmd_byte;
            `DSH_OFF_DSN2_NV: st_next.dsn_nv[2] = cmd_byte;
            `DSH_OFF_DSN1_NV: st_next.dsn_nv[1] = cmd_byte;
            `DSH_OFF_DSN0_NV: st_next.dsn_nv[0] = cmd_byte;
            `DSH_OFF_EXF:     st_next.exf       = cmd_byte;
            `DSH_OFF_EXF_NV:  st_next.exf_nv    = cmd_byte;
            `DSH_OFF_HOLD:    st_next.hold      = cmd_byte;
            `DSH_OFF_HOLD_NV: st_next.hold_nv   = cmd_byte;
            default:          ;                               // Other locations ignored
          endcase
          st_next.cmd = DSH_IDLE;
        end
        default: st_next.cmd = DSH_IDLE;
      endcase
    end

    // Answer sequencing, one byte per accepted slot
    if (ans_push)
    begin
      unique case (st_reg.ans)
        DSH_ANS_ACK:  st_next.ans = DSH_ANS_ADR;
        DSH_ANS_ADR:  st_next.ans = DSH_ANS_VAL;
        DSH_ANS_VAL:  st_next.ans = DSH_ANS_IDLE;
        DSH_ANS_IDLE: st_next.ans = DSH_ANS_IDLE;
      endcase
    end

    // Exception engine; a new event wins over a clearing read
    if (exc_clear)
      st_next.ex_line = 1'b0;
    if (exc_valid)
    begin
      st_next.exc_code_reg = exc_code;
      if ((exc_code & st_reg.exf) != 8'h00)
        st_next.ex_line = 1'b1;
    end

    // Radio buffer pointers; a full buffer drops and flags
    if (rf_valid)
    begin
      if (!rf_full)
        st_next.wp = st_reg.wp + 1'b1;
      else
        st_next.ovf = 1'b1;
    end
    if (rf_push)
      st_next.rp = st_reg.rp + 1'b1;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_reg          <= '0;
      st_reg.exf      <= `DSH_RST_EXF;
      st_reg.exf_nv   <= `DSH_RST_EXF;
      st_reg.hold     <= `DSH_RST_HOLD;
      st_reg.hold_nv  <= `DSH_RST_HOLD;
      st_reg.cmd      <= DSH_IDLE;
      st_reg.ans      <= DSH_ANS_IDLE;
      st_reg.cmd_sync <= 2'b11;
    end
    else
      st_reg <= st_next;
  end

  // Radio memory write, no reset needed for data
  always_ff @(posedge clock)
  begin
    if (rf_valid && !rf_full)
      rf_mem[st_reg.wp[`DSH_RF_AW-1:0]] <= rf_byte;
  end

  // ****************************************
  // Output buffer; receiver stall reaches rf_push
  // ****************************************
  dsh_skid u_skid (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (buf_out_valid),
    .out_ready (tx_ready),
    .out_data  (buf_out)
  );

  // Outputs straight from flip-flops
  assign tx_valid                  = buf_out_valid;
  assign tx_byte                   = buf_out.data;
  assign command_response_line     = buf_out.is_data;
  assign exception_output_line     = st_reg.ex_line;
  assign rf_overflow               = st_reg.ovf;
  assign destination_serial_number = st_reg.device_serial_number;
endmodule : dsh_regs
`default_nettype wire

// ---- dv/dsh_regs_checker.sv ----
/*
  Concurrent checks on the ports of the register group.
  Assumes one clock, active-high asynchronous reset, bound to dsh_regs.
*/
`timescale 1ns/1ps
`default_nettype none
module dsh_regs_checker
  import dsh_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_byte,
  input wire logic        rf_valid,
  input wire logic        exc_valid,
  input wire logic [7:0]  exc_code,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_byte,
  input wire logic        command_response_line,
  input wire logic        tx_ready,
  input wire logic        exception_output_line,
  input wire logic        rf_overflow,
  input wire logic [31:0] destination_serial_number
);
  // ****************************************
  // Frame shapes
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Header and size bytes, back to back
  sequence hdr_s;
    cmd_valid && cmd_byte == 8'hff ##1 cmd_valid && cmd_byte == 8'h02;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  AST_DSN_MSB: assert property (hdr_s ##1 cmd_valid && cmd_byte == 8'h68 ##1 cmd_valid
    |=> destination_serial_number[31:24] == $past(cmd_byte)) else $error("serial msb not written");
  AST_DSN_LSB: assert property (hdr_s ##1 cmd_valid && cmd_byte == 8'h6b ##1 cmd_valid
    |=> destination_serial_number[7:0] == $past(cmd_byte)) else $error("serial lsb not written");
  AST_DSN_BY_CMD: assert property (!$stable(destination_serial_number) |-> $past(cmd_valid))
    else $error("serial changed without a command byte");
  AST_EX_CAUSE: assert property ($rose(exception_output_line)
    |-> $past(exc_valid) || $past(exc_valid, 2)) else $error("exception line rose without event");
  AST_EX_ZERO: assert property (exc_valid && exc_code == 8'h00 && !exception_output_line
    && !$past(exc_valid) |=> !exception_output_line [*2]) else $error("zero code raised line");
  AST_EX_CLEAR: assert property (hdr_s ##1 cmd_valid && cmd_byte == 8'hfe
    ##1 cmd_valid && cmd_byte == 8'h6d && !exc_valid ##1 !exc_valid [*2]
    |-> !exception_output_line) else $error("code read left line high");
  AST_ACK_FIRST: assert property (hdr_s ##1 cmd_valid && cmd_byte == 8'hfe
    ##1 cmd_valid && !tx_valid && !rf_valid
    |-> ##2 tx_valid && tx_byte == 8'h06 && !command_response_line) else $error("no ack first");
  AST_TX_STANDS: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_byte) && $stable(command_response_line)) else $error("tx byte dropped");
  // Main scenarios reached
  cover property (rf_overflow);
  cover property ($rose(exception_output_line));
  cover property (tx_valid && tx_ready && command_response_line);
endmodule : dsh_regs_checker

bind dsh_regs dsh_regs_checker i_chk (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_byte(cmd_byte), .rf_valid(rf_valid), .exc_valid(exc_valid), .exc_code(exc_code),
  .tx_valid(tx_valid), .tx_byte(tx_byte), .command_response_line(command_response_line),
  .tx_ready(tx_ready), .exception_output_line(exception_output_line), .rf_overflow(rf_overflow),
  .destination_serial_number(destination_serial_number));
`default_nettype wire

// ---- dv/dsh_host.sv ----
/*
  Host model: sends command frames and takes every byte sent back.
  Assumes stimulus at the falling edge of the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dsh_host
  import dsh_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       stall_en,
  output logic            cmd_valid,
  output logic [7:0]      cmd_byte,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  input  wire logic       command_response_line,
  output logic            tx_ready
);
  int        seed = 93;  // Fixed seed, repeatable stalls
  dsh_byte_t rx_q[$];    // Bytes taken from the device
  initial
  begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
    tx_ready  = 1'b1;
  end
  // ****************************************
  // Receiver
  // ****************************************
  // Byte taken on the edge that sees ready high
  always @(posedge clock)
    if (tx_valid && tx_ready)
      rx_q.push_back('{command_response_line, tx_byte});
  // Random stalls test that nothing is lost
  always @(negedge clock)
    tx_ready <= !stall_en || ($random(seed) & 1) == 1;
  // ****************************************
  // Frames
  // ****************************************
  // Four bytes, one per cycle; the line shows junk once released
  task automatic send(input logic [31:0] f);
    for (int i = 3; i >= 0; i--)
    begin
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_byte  = f[8*i +: 8];
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_byte  = ~cmd_byte;
  endtask : send
  // One location per command, serial bytes included
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    send({8'hff, 8'h02, a, v});
  endtask : write_reg
  // Read of one location; the answer is ack, address echo and value
  task automatic read_reg(input logic [7:0] a);
    send({8'hff, 8'h02, 8'hfe, a});
  endtask : read_reg
endmodule : dsh_host
`default_nettype wire

// ---- dv/dsh_regs_test.sv ----
/*
  Self-checking bench of the register group against a queue model.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module dsh_regs_test
  import dsh_pkg::*;
;
  logic        clock, rst, cmd_valid, rf_valid, exc_valid, cmd_line_n, receive_packet_option;
  logic        tx_valid, command_response_line, tx_ready, exception_output_line, rf_overflow, stall_en;
  logic [7:0]  cmd_byte, rf_byte, exc_code, tx_byte;
  logic [31:0] destination_serial_number;
  logic [7:0]  mdl [256];  // Expected register contents
  dsh_byte_t   exp_q[$];   // Expected bytes out
  int          errors, comparisons, cyc;
  int          seed = 93;
  logic [7:0]  regs [12] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h23, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h6e};
  logic [7:0]  filt [6] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h60, 8'hff};
  logic [7:0]  codes [9] = '{8'h08, 8'h09, 8'h10, 8'h20, 8'h40, 8'h41, 8'h42, 8'h43, 8'h00};
  dsh_regs i_dut (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .rf_valid(rf_valid), .rf_byte(rf_byte), .exc_valid(exc_valid), .exc_code(exc_code),
    .cmd_line_n(cmd_line_n), .receive_packet_option(receive_packet_option), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .command_response_line(command_response_line), .tx_ready(tx_ready),
    .exception_output_line(exception_output_line), .rf_overflow(rf_overflow),
    .destination_serial_number(destination_serial_number));
  dsh_host i_host (.clock(clock), .stall_en(stall_en), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .command_response_line(command_response_line),
    .tx_ready(tx_ready));
  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Whole run needs well under this many cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  // ****************************************
  // Compare and drive tasks
  // ****************************************
  task automatic chk_pin(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk_pin
  // Waits for the expected bytes, then matches them in order
  task automatic drain();
    int n;
    n = 0;
    while (i_host.rx_q.size() < exp_q.size() && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
    chk_pin("byte count", exp_q.size(), i_host.rx_q.size());
    while (exp_q.size() > 0 && i_host.rx_q.size() > 0)
      chk_pin("tx byte", exp_q.pop_front(), i_host.rx_q.pop_front());
    exp_q.delete();
    i_host.rx_q.delete();
  endtask : drain
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_host.write_reg(a, v);
    mdl[a] = v;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_host.read_reg(a);
    exp_q.push_back('{1'b0, 8'h06});
    exp_q.push_back('{1'b0, a});
    exp_q.push_back('{1'b0, mdl[a]});
    drain();
  endtask : rd
  task automatic radio(input int n, input int keep);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clock);
      rf_valid = 1'b1;
      rf_byte  = 8'($random(seed));
      if (i < keep)
        exp_q.push_back('{1'b1, rf_byte});
    end
    @(negedge clock);
    rf_valid = 1'b0;
    rf_byte  = ~rf_byte;
  endtask : radio
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst, stall_en, cmd_line_n} = 3'b101;
    {rf_valid, exc_valid, receive_packet_option} = 3'b000;
    rf_byte  = 8'h00;
    exc_code = 8'h00;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h21] = 8'hff;
    mdl[8'h6c] = 8'hff;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    foreach (regs[i]) rd(regs[i]);
    stall_en = 1'b1;
    foreach (regs[i]) wr(regs[i], 8'($random(seed)));
    i_host.write_reg(8'h22, 8'h5a);
    foreach (regs[i]) rd(regs[i]);
    rd(8'h22);
    chk_pin("serial", {mdl[8'h68], mdl[8'h69], mdl[8'h6a], mdl[8'h6b]}, destination_serial_number);
    $display("test registers done");
    foreach (filt[i])
    begin
      wr(8'h6c, filt[i]);
      foreach (codes[j])
      begin
        @(negedge clock);
        exc_valid = 1'b1;
        exc_code  = codes[j];
        @(negedge clock);
        exc_valid = 1'b0;
        exc_code  = ~codes[j];
        mdl[8'h6d] = codes[j];
        repeat (3) @(negedge clock);
        chk_pin("exception line", (codes[j] & filt[i]) != 8'h00, exception_output_line);
        rd(8'h6d);
        chk_pin("exception line", 32'h0, exception_output_line);
      end
    end
    $display("test exceptions done");
    wr(8'h6e, 8'h00);
    radio(6, 6);
    drain();
    wr(8'h6e, 8'h01);
    cmd_line_n = 1'b0;
    receive_packet_option = 1'b1;
    repeat (4) @(negedge clock);
    radio(5, 5);
    drain();
    receive_packet_option = 1'b0;
    repeat (4) @(negedge clock);
    radio(65, 64);
    repeat (10) @(negedge clock);
    chk_pin("held count", 32'h0, i_host.rx_q.size());
    chk_pin("overflow", 32'h1, rf_overflow);
    cmd_line_n = 1'b1;
    drain();
    $display("test traffic hold done");
    // Raise the line, then reset mid-run: sticky flags must drop
    @(negedge clock);
    exc_valid = 1'b1;
    exc_code  = 8'h10;
    @(negedge clock);
    exc_valid = 1'b0;
    exc_code  = 8'hef;
    repeat (2) @(negedge clock);
    chk_pin("exception line", 32'h1, exception_output_line);
    rst = 1'b1;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chk_pin("exception line", 32'h0, exception_output_line);
    chk_pin("overflow", 32'h0, rf_overflow);
    chk_pin("serial", 32'h0, destination_serial_number);
    mdl[8'h6e] = 8'h00;
    rd(8'h6e);
    $display("test reset done");
    report_and_stop();
  end
endmodule : dsh_regs_test
`default_nettype wire
